// >>> imc_regs.sv
// Purpose: Threshold and interrupt enable registers with their effects.
// Assumes: The modem SPI slave hands decoded register accesses to this
//          block; the CCA engine sits outside, the status register sits inside.
// Notes:   Reads answer one clock after the request with a valid pulse.
//
// What this block does
// - Eight-bit threshold, upper byte, resets zero.
// - Add half offset to energy or LQI.
// - Offset byte resets to 8d.
// - Interrupt when enabled status bit is true.
// - Reading status clears the pending interrupt.
// - Disabled sources still set status bits.
// - Bit 15 enables attention, set at reset.
// - Bit 12 enables packet RAM address error.
// - Bit 11 enables RAM arbiter busy error.
// - Bit 10 enables stream data error.
// - Bit 9 enables oscillator unlock interrupt.
// - Deep doze waits attention, stops timer clocks.
// - Normal doze exits on compare two or attention.
// - Bit 4 enables doze timer interrupt.
// - Bits 3..0 enable compare four..one.
// - Receive stream event; data read clears it.
`timescale 1ns/1ps
module imc_regs (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// Decoded register access from the SPI slave.
	input  wire imc_pkg::imc_reg_req_t reg_req_i,
	output logic               [15:0] reg_rdata_o,
	output logic                      reg_rvalid_o,
	// Status register read and receive data port read strobes.
	input  wire logic                 status_rd_i,
	input  wire logic                 rx_data_rd_i,
	// Interrupt sources.
	input  wire imc_pkg::imc_ev_t     events_i,
	input  wire logic                 rx_strm_word_i,
	input  wire logic                 rx_strm_en_i,
	// Measurements to be compensated.
	input  wire logic                 measure_valid_i,
	input  wire logic           [7:0] measure_i,
	// Doze control.
	input  wire logic                 doze_req_i,
	input  wire logic                 attn_i,
	// Results and state.
	output logic                [7:0] channel_clear_threshold_o,
	output logic                [7:0] assess_result_o,
	output logic                      assess_valid_o,
	output logic               [15:0] status_o,
	output logic                      rx_strm_o,
	output logic                      irq_o,
	output logic                      dozing_o,
	output logic                      timer_clk_en_o
);

	// All register state of this module.
	typedef struct packed {
		logic [7:0]  thresh;
		logic [7:0]  comp;
		logic [15:0] ien;
		logic [15:0] rdata;
		logic        rvalid;
		logic [7:0]  result;
		logic        result_valid;
	} imc_regs_st_t;

	imc_regs_st_t st_reg;
	imc_regs_st_t st_next;

	logic [15:0] event_vec;
	logic [8:0]  comp_sum;
	logic        thresh_sel;
	logic        ien_sel;

	// Address decode of the two registers.
	assign thresh_sel = (reg_req_i.addr == imc_pkg::THRESH_ADDR);
	assign ien_sel    = (reg_req_i.addr == imc_pkg::IEN_ADDR);

	// Events placed at their enable bit positions.
	assign event_vec = imc_pkg::ev_vector(events_i);

	// Offset is halved before the add; the sum saturates rather than wraps
	// so a large gain offset cannot fold a strong signal into a weak one.
	assign comp_sum = {1'b0, measure_i} + {2'b00, st_reg.comp[7:1]};

	// Next state of the register file and the result path.
	always_comb begin
		st_next = st_reg;
		st_next.rvalid = 1'b0;
		st_next.result_valid = 1'b0;

		// Register writes; the host owns the encoding of each value.
		if (reg_req_i.wr && thresh_sel) begin
			st_next.thresh = reg_req_i.wdata[imc_pkg::THRESH_LSB +: 8];
			st_next.comp   = reg_req_i.wdata[imc_pkg::COMP_LSB +: 8];
		end
		if (reg_req_i.wr && ien_sel) begin
			// Reserved bits are held at their reset value.
			st_next.ien = (reg_req_i.wdata & imc_pkg::IEN_WR_MASK)
				| (imc_pkg::IEN_RESET & ~imc_pkg::IEN_WR_MASK);
		end

		// Register reads; an unmapped number answers zero.
		if (reg_req_i.rd) begin
			st_next.rvalid = 1'b1;
			if (thresh_sel) begin
				st_next.rdata = {st_reg.thresh, st_reg.comp};
			end else if (ien_sel) begin
				st_next.rdata = st_reg.ien;
			end else begin
				st_next.rdata = 16'h0000;
			end
		end

		// Compensated assessment result.
		if (measure_valid_i) begin
			st_next.result_valid = 1'b1;
			if (comp_sum[8]) begin
				st_next.result = 8'hff;
			end else begin
				st_next.result = comp_sum[7:0];
			end
		end
	end

	// Register stage; reset loads the documented defaults.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg.thresh       <= imc_pkg::THRESH_RESET;
			st_reg.comp         <= imc_pkg::COMP_RESET;
			st_reg.ien          <= imc_pkg::IEN_RESET;
			st_reg.rdata        <= 16'h0000;
			st_reg.rvalid       <= 1'b0;
			st_reg.result       <= 8'h00;
			st_reg.result_valid <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign channel_clear_threshold_o = st_reg.thresh;
	assign assess_result_o           = st_reg.result;
	assign assess_valid_o            = st_reg.result_valid;
	assign reg_rdata_o               = st_reg.rdata;
	assign reg_rvalid_o              = st_reg.rvalid;

	// Status latching and interrupt gating by bits 15, 12..9, 4 and 3..0.
	imc_status u_status (
		.clk_i         (clk_i),
		.rst_i         (rst_i),
		.event_vec_i   (event_vec),
		.ien_i         (st_reg.ien),
		.status_rd_i   (status_rd_i),
		.rx_strm_set_i (rx_strm_word_i),
		.rx_strm_en_i  (rx_strm_en_i),
		.rx_data_rd_i  (rx_data_rd_i),
		.status_o      (status_o),
		.rx_strm_o     (rx_strm_o),
		.irq_o         (irq_o)
	);

	// Doze control; deep doze comes straight from the enable register.
	imc_doze u_doze (
		.clk_i               (clk_i),
		.rst_i               (rst_i),
		.doze_req_i          (doze_req_i),
		.deep_doze_i         (st_reg.ien[imc_pkg::DEEP_DOZE_BIT]),
		.attn_i              (attn_i),
		.timer_compare_two_i (events_i.compare_two_event),
		.dozing_o            (dozing_o),
		.timer_clk_en_o      (timer_clk_en_o)
	);

endmodule

// >>> imc_pkg.sv
// Purpose: Shared constants and carrier types of the mask and threshold block.
// Assumes: Register addresses are the modem register numbers, not bytes.
// Notes:   Status bit positions mirror the enable bit positions.
package imc_pkg;

	// Register numbers on the modem register port.
	localparam logic [5:0]  THRESH_ADDR     = 6'h04;
	localparam logic [5:0]  IEN_ADDR        = 6'h05;

	// Field positions of the threshold register.
	localparam int          THRESH_LSB      = 8;
	localparam int          COMP_LSB        = 0;

	// Reset values.
	localparam logic [7:0]  THRESH_RESET    = 8'h00;
	localparam logic [7:0]  COMP_RESET      = 8'h8d;
	localparam logic [15:0] IEN_RESET       = 16'h8000;

	// Bit positions of the enable register and the status vector.
	localparam int          ATTN_BIT        = 15;
	localparam int          RAM_ADDR_BIT    = 12;
	localparam int          ARB_BUSY_BIT    = 11;
	localparam int          STRM_ERR_BIT    = 10;
	localparam int          PLL_BIT         = 9;
	localparam int          DEEP_DOZE_BIT   = 8;
	localparam int          DOZE_BIT        = 4;
	localparam int          CMP_FOUR_BIT    = 3;
	localparam int          CMP_THREE_BIT   = 2;
	localparam int          CMP_TWO_BIT     = 1;
	localparam int          CMP_ONE_BIT     = 0;

	// Bits that gate sources, and bits software may change.
	localparam logic [15:0] IEN_SRC_MASK    = 16'h9e1f;
	localparam logic [15:0] IEN_WR_MASK     = 16'h9f1f;

	// One register access from the modem register port.
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [5:0]  addr;
		logic [15:0] wdata;
	} imc_reg_req_t;

	// Interrupt source events, one-cycle pulses.
	typedef struct packed {
		logic attn;
		logic ram_addr_err;
		logic arb_busy_err;
		logic strm_data_err;
		logic pll_unlock;
		logic doze;
		logic compare_four_event;
		logic compare_three_event;
		logic compare_two_event;
		logic compare_one_event;
	} imc_ev_t;

	// Places the events at their enable bit positions.
	function automatic logic [15:0] ev_vector(input imc_ev_t ev);
		logic [15:0] v;
		v                = 16'h0000;
		v[ATTN_BIT]      = ev.attn;
		v[RAM_ADDR_BIT]  = ev.ram_addr_err;
		v[ARB_BUSY_BIT]  = ev.arb_busy_err;
		v[STRM_ERR_BIT]  = ev.strm_data_err;
		v[PLL_BIT]       = ev.pll_unlock;
		v[DOZE_BIT]      = ev.doze;
		v[CMP_FOUR_BIT]  = ev.compare_four_event;
		v[CMP_THREE_BIT] = ev.compare_three_event;
		v[CMP_TWO_BIT]   = ev.compare_two_event;
		v[CMP_ONE_BIT]   = ev.compare_one_event;
		return v;
	endfunction

endpackage

// >>> imc_status.sv
// Purpose: Sticky status bits and the single interrupt output.
// Assumes: Events are one-cycle pulses synchronous to clk_i.
// Notes:   A set in the cycle of a clear wins, so no event is lost.
`timescale 1ns/1ps
module imc_status (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [15:0] event_vec_i,
	input  wire logic [15:0] ien_i,
	input  wire logic        status_rd_i,
	input  wire logic        rx_strm_set_i,
	input  wire logic        rx_strm_en_i,
	input  wire logic        rx_data_rd_i,
	output logic      [15:0] status_o,
	output logic             rx_strm_o,
	output logic             irq_o
);

	typedef struct packed {
		logic [15:0] status;
		logic        rx_strm;
		logic        irq;
	} imc_status_st_t;

	imc_status_st_t st_reg;
	imc_status_st_t st_next;

	// Status bits latch even with the enable low; only the pin is gated.
	always_comb begin
		st_next = st_reg;
		st_next.status = (st_reg.status & ~{16{status_rd_i}})
			| (event_vec_i & imc_pkg::IEN_SRC_MASK);
		st_next.rx_strm = (st_reg.rx_strm & ~(status_rd_i | rx_data_rd_i))
			| rx_strm_set_i;
		st_next.irq = |(st_next.status & ien_i & imc_pkg::IEN_SRC_MASK)
			| (st_next.rx_strm & rx_strm_en_i);
	end

	// Single register stage keeps the pin glitch free.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign status_o  = st_reg.status;
	assign rx_strm_o = st_reg.rx_strm;
	assign irq_o     = st_reg.irq;

endmodule

// >>> imc_doze.sv
// Purpose: Doze exit control and timer clock enable.
// Assumes: Doze entry request comes from the modem sequencer.
// Notes:   Deep doze ignores the timer compare, so only attention wakes.
`timescale 1ns/1ps
module imc_doze (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic doze_req_i,
	input  wire logic deep_doze_i,
	input  wire logic attn_i,
	input  wire logic timer_compare_two_i,
	output logic      dozing_o,
	output logic      timer_clk_en_o
);

	typedef enum logic {
		IMC_AWAKE,
		IMC_DOZE
	} imc_doze_state_t;

	typedef struct packed {
		imc_doze_state_t state;
		logic            clk_en;
	} imc_doze_st_t;

	imc_doze_st_t st_reg;
	imc_doze_st_t st_next;

	// Wake conditions depend on the deep doze enable.
	always_comb begin
		st_next = st_reg;
		unique case (st_reg.state)
			IMC_AWAKE: begin
				if (doze_req_i) begin
					st_next.state = IMC_DOZE;
				end
			end
			IMC_DOZE: begin
				if (attn_i) begin
					st_next.state = IMC_AWAKE;
				end else if (!deep_doze_i && timer_compare_two_i) begin
					st_next.state = IMC_AWAKE;
				end
			end
		endcase
		st_next.clk_en = !(st_next.state == IMC_DOZE && deep_doze_i);
	end

	// State register.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_reg <= '{state: IMC_AWAKE, clk_en: 1'b1};
		end else begin
			st_reg <= st_next;
		end
	end

	assign dozing_o       = (st_reg.state == IMC_DOZE);
	assign timer_clk_en_o = st_reg.clk_en;

endmodule

// >>> imc_regs_monitor.sv
// Purpose: Port checks on the mask and threshold block.
// Assumes: One clock, synchronous active high reset.
// Notes:   Bound to every instance of the block.
`timescale 1ns/1ps
module imc_regs_monitor (
	input wire logic                  clk_i,
	input wire logic                  rst_i,
	input wire imc_pkg::imc_reg_req_t reg_req_i,
	input wire logic                  reg_rvalid_o,
	input wire logic                  status_rd_i,
	input wire logic                  rx_data_rd_i,
	input wire imc_pkg::imc_ev_t      events_i,
	input wire logic                  rx_strm_word_i,
	input wire logic                  measure_valid_i,
	input wire logic                  attn_i,
	input wire logic [7:0]            channel_clear_threshold_o,
	input wire logic                  assess_valid_o,
	input wire logic [15:0]           status_o,
	input wire logic                  rx_strm_o,
	input wire logic                  irq_o,
	input wire logic                  dozing_o,
	input wire logic                  timer_clk_en_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// A clear only empties status when no new set races it.
	sequence s_clear;
		status_rd_i && events_i == '0 && !rx_strm_word_i;
	endsequence
	sequence s_wake;
		dozing_o && attn_i;
	endsequence

	// Checks tie an output to its cause one cycle earlier, except a_irq_cause and a_clk_awake, which check the same cycle.
	a_read_answer: assert property (reg_req_i.rd |=> reg_rvalid_o)
		else $error("read gave no answer");
	a_no_stray: assert property (!reg_req_i.rd |=> !reg_rvalid_o)
		else $error("answer without a read");
	a_thresh_write: assert property (reg_req_i.wr &&
		reg_req_i.addr == imc_pkg::THRESH_ADDR |=>
		channel_clear_threshold_o == $past(reg_req_i.wdata[15:8]))
		else $error("threshold not taken from write");
	a_result_valid: assert property (measure_valid_i |=> assess_valid_o)
		else $error("no result after measurement");
	a_status_sets: assert property (events_i.compare_one_event |=>
		status_o[0]) else $error("status bit not set");
	a_irq_cause: assert property (status_o == '0 && !rx_strm_o |->
		!irq_o) else $error("interrupt with no status");
	a_read_clears: assert property (s_clear |=>
		status_o == '0 && !irq_o) else $error("status read did not clear");
	a_attn_wakes: assert property (s_wake |=> !dozing_o)
		else $error("attention did not wake");
	a_clk_awake: assert property (!dozing_o |-> timer_clk_en_o)
		else $error("timer clock stopped while awake");
	a_rx_clear: assert property (rx_data_rd_i && !rx_strm_word_i |=>
		!rx_strm_o) else $error("data read did not clear stream");
endmodule

bind imc_regs imc_regs_monitor mon (.clk_i, .rst_i, .reg_req_i,
	.reg_rvalid_o, .status_rd_i, .rx_data_rd_i, .events_i,
	.rx_strm_word_i, .measure_valid_i, .attn_i,
	.channel_clear_threshold_o, .assess_valid_o, .status_o,
	.rx_strm_o, .irq_o, .dozing_o, .timer_clk_en_o);

// >>> imc_host_model.sv
// Purpose: Host side of the register port.
// Assumes: Tasks are entered just after a rising edge.
// Notes:   Released lines show inverted data so stale values never match.
`timescale 1ns/1ps
module imc_host_model (
	input  wire logic                  clk_i,
	input  wire logic [15:0]           rdata_i,
	input  wire logic                  rvalid_i,
	output imc_pkg::imc_reg_req_t      req_o
);
	initial req_o = '0;

	// A write is taken at the next edge and gives no answer.
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_i);
		req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
		// One idle edge, so that a following call never drives the
		// request again in the same time step as this release.
		@(posedge clk_i);
	endtask

	// A read waits a bounded time for the answer pulse.
	task automatic rd(input logic [5:0] a, output logic [15:0] d);
		req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge clk_i);
		req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hffff};
		for (int n = 0; n < 4 && !rvalid_i; n++)
			@(posedge clk_i);
		d = rvalid_i ? rdata_i : 16'hxxxx;
	endtask
endmodule

// >>> imc_regs_tb_top.sv
// Purpose: Self-checking bench for the mask and threshold block.
// Assumes: Host model makes register accesses; bench drives events.
// Notes:   Random bytes come from an LFSR that starts at 93.
`timescale 1ns/1ps
module imc_regs_tb_top;
	logic                  clk_i, rst_i, rvalid, res_v, rx_strm, irq;
	logic                  st_rd, rx_rd, rx_word, rx_en, meas_v;
	logic                  doze_req, attn, dozing, clk_en;
	logic [7:0]            meas, thr, res, lfsr, o, t, m;
	logic [15:0]           rdata, status, v;
	imc_pkg::imc_reg_req_t req;
	imc_pkg::imc_ev_t      ev;
	int                    fail_count, checks;
	int                    pos[10] = '{0, 1, 2, 3, 4, 9, 10, 11, 12, 15};

	imc_host_model host (.clk_i, .rdata_i(rdata), .rvalid_i(rvalid),
		.req_o(req));
	imc_regs dut (.clk_i, .rst_i, .reg_req_i(req), .reg_rdata_o(rdata),
		.reg_rvalid_o(rvalid), .status_rd_i(st_rd), .rx_data_rd_i(rx_rd),
		.events_i(ev), .rx_strm_word_i(rx_word), .rx_strm_en_i(rx_en),
		.measure_valid_i(meas_v), .measure_i(meas), .doze_req_i(doze_req),
		.attn_i(attn), .channel_clear_threshold_o(thr),
		.assess_result_o(res), .assess_valid_o(res_v), .status_o(status),
		.rx_strm_o(rx_strm), .irq_o(irq), .dozing_o(dozing),
		.timer_clk_en_o(clk_en));

	function automatic logic [7:0] nxt(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// Host encoding: twice the dBm magnitude.
	function automatic logic [7:0] thr_code(input int dbm);
		return 8'(dbm < 0 ? -dbm * 2 : dbm * 2);
	endfunction
	// Sum saturates, so a large offset never wraps to a small value.
	function automatic logic [7:0] exp_res(input logic [7:0] a, b);
		logic [8:0] s;
		s = {1'b0, a} + {2'h0, b[7:1]};
		return s[8] ? 8'hff : s[7:0];
	endfunction

	task automatic chk(input logic [15:0] got, exp, input string w);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %0t %s got %h exp %h", $time, w, got, exp);
		end
	endtask
	// One strobe high for one edge; w 6 only carries the event word.
	task automatic pulse(input int w);
		{meas_v, rx_word, rx_rd, st_rd, attn, doze_req} <= 6'h01 << w;
		@(posedge clk_i);
		{meas_v, rx_word, rx_rd, st_rd, attn, doze_req} <= 6'h00;
		ev <= '0;
		@(posedge clk_i);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Free-running clock at 40 ns.
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	// Cuts a hang short well past the expected run length.
	initial begin
		repeat (4000) @(posedge clk_i);
		fail_count++;
		$display("MISMATCH %0t watchdog expired", $time);
		summarize();
	end

	initial begin
		{st_rd, rx_rd, rx_word, rx_en, meas_v, doze_req, attn} = '0;
		ev = '0;
		meas = 8'h00;
		lfsr = 8'h5d;
		rst_i = 1'b1;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		host.rd(6'h04, v);
		chk(v, 16'h008d, "thresh reset");
		host.rd(6'h05, v);
		chk(v, 16'h8000, "enable reset");
		host.rd(6'h3f, v);
		chk(v, 16'h0000, "unmapped");
		host.wr(6'h05, 16'hffff);
		host.rd(6'h05, v);
		chk(v, 16'h9f1f, "reserved bits");
		$display("test registers done");
		for (int e = 1; e >= 0; e--) begin
			host.wr(6'h05, e ? 16'h9e1f : 16'h0000);
			for (int k = 0; k < 10; k++) begin
				ev <= imc_pkg::imc_ev_t'(10'h001 << k);
				pulse(6);
				chk(status, 16'h0001 << pos[k], "status");
				chk(irq, e[0], "irq");
				pulse(2);
				chk(status, 16'h0000, "status clear");
				chk(irq, 1'b0, "irq clear");
			end
		end
		$display("test interrupts done");
		for (int i = 0; i < 6; i++) begin
			lfsr = nxt(lfsr);
			o = i == 0 ? 8'h9b : lfsr;
			lfsr = nxt(lfsr);
			t = i == 0 ? thr_code(-75) : lfsr;
			lfsr = nxt(lfsr);
			m = i == 5 ? 8'hff : lfsr;
			host.wr(6'h04, {t, o});
			meas <= m;
			pulse(5);
			chk(thr, t, "threshold");
			chk(res_v, 1'b1, "result valid");
			chk(res, exp_res(m, o), "result");
		end
		$display("test measurement done");
		host.wr(6'h05, 16'h0100);
		pulse(0);
		chk({dozing, clk_en}, 2'h2, "deep doze");
		ev <= imc_pkg::imc_ev_t'(10'h002);
		pulse(6);
		chk(dozing, 1'b1, "compare in deep doze");
		pulse(1);
		chk({dozing, clk_en}, 2'h1, "attention wake");
		host.wr(6'h05, 16'h0000);
		pulse(0);
		chk({dozing, clk_en}, 2'h3, "doze");
		ev <= imc_pkg::imc_ev_t'(10'h002);
		pulse(6);
		chk(dozing, 1'b0, "compare wake");
		$display("test doze done");
		rx_en <= 1'b1;
		pulse(2);
		pulse(4);
		chk({rx_strm, irq}, 2'h3, "stream word");
		pulse(3);
		chk({rx_strm, irq}, 2'h0, "stream read");
		// An event in the cycle of a status read must survive the clear.
		ev <= imc_pkg::imc_ev_t'(10'h001);
		pulse(2);
		chk(status, 16'h0001, "set beats clear");
		pulse(2);
		$display("test stream done");
		// A reset in mid-run, taken while dozing, restores every default.
		pulse(0);
		chk(dozing, 1'b1, "doze before reset");
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		host.rd(6'h04, v);
		chk(v, 16'h008d, "thresh after reset");
		host.rd(6'h05, v);
		chk(v, 16'h8000, "enable after reset");
		chk({dozing, clk_en, irq}, 3'h2, "state after reset");
		$display("test reset done");
		summarize();
	end
endmodule
